// file: scc_pkg.sv
// Package of constants for the sleep control and configuration register block.
package scc_pkg;
	localparam int          SCC_ADDR_W         = 12;
	localparam logic [11:0] SCC_OFF_SLEEP_CTRL = 12'h000;
	localparam logic [11:0] SCC_OFF_PWR_CFG    = 12'h004;
	localparam logic [11:0] SCC_OFF_STATE      = 12'h008;
	localparam int          SCC_SLEEP_REQ_BIT  = 0;
	localparam int          SCC_FAST_OSC_BIT   = 0;
	localparam int          SCC_FLOAT_CARD_BIT = 1;
	localparam int          SCC_FLOAT_MEM_BIT  = 2;
	localparam int          SCC_SLOW_OK_BIT    = 3;
	localparam int          SCC_CFG_W          = 4;
	localparam int          SCC_ST_SLEEP_BIT   = 0;
	localparam int          SCC_ST_SLOW_BIT    = 1;
	localparam int          SCC_ST_FASTOFF_BIT = 2;
	localparam logic [31:0] SCC_SLEEP_CTRL_RST = 32'h00000000;
	localparam logic [3:0]  SCC_PWR_CFG_RST    = 4'h0;
	localparam int          SCC_CARD_EN_W      = 2;
	localparam int          SCC_CS_W           = 4;
endpackage

// file: scc_cfg_if.sv
// Interface carrying sleep state and pin configuration to the pin control module.
interface scc_cfg_if;
	logic in_sleep;
	logic float_card;
	logic float_mem;
	modport ctrl (output in_sleep, output float_card, output float_mem);
	modport pins (input in_sleep, input float_card, input float_mem);
endinterface

// file: scc_pin_ctl.sv
// Sleep-time drive and float control of the card and static memory control pins.
module scc_pin_ctl
	import scc_pkg::*;
(
	input  wire logic                     pclk,
	input  wire logic                     presetn,
	scc_cfg_if.pins                       cfg,
	input  wire logic [7+SCC_CARD_EN_W-1:0] card_run,
	input  wire logic [2+SCC_CS_W-1:0]    mem_run,
	input  wire logic                     socket_select_run,
	input  wire logic                     card_attr_space_n_run,
	output logic      [7+SCC_CARD_EN_W-1:0] card_out,
	output logic      [7+SCC_CARD_EN_W-1:0] card_oe,
	output logic      [2+SCC_CS_W-1:0]    mem_out,
	output logic      [2+SCC_CS_W-1:0]    mem_oe,
	output logic                          socket_select,
	output logic                          card_attr_space_n
);
	localparam int CW = 7 + SCC_CARD_EN_W;
	localparam int MW = 2 + SCC_CS_W;

	// ****************************************
	// Pin registers
	// ****************************************
	// In sleep the strobes sit at their negated (high) level unless floated.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			card_out <= '1;
			card_oe  <= '1;
		end else if (cfg.in_sleep) begin
			card_out <= '1;
			card_oe  <= {CW{~cfg.float_card}};
		end else begin
			card_out <= card_run;
			card_oe  <= '1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mem_out <= '1;
			mem_oe  <= '1;
		end else if (cfg.in_sleep) begin
			mem_out <= '1;
			mem_oe  <= {MW{~cfg.float_mem}};
		end else begin
			mem_out <= mem_run;
			mem_oe  <= '1;
		end
	end

	// These follow the address bus in every mode, so the float setting never touches them.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			socket_select     <= 1'b0;
			card_attr_space_n <= 1'b1;
		end else begin
			socket_select     <= socket_select_run;
			card_attr_space_n <= card_attr_space_n_run;
		end
	end
endmodule // scc_pin_ctl

// file: scc_top.sv
// Sleep control and power configuration registers behind an APB slave.
// How it works
// - Writing one to request bit starts sleep.
// - Request clears on wake-up and reset.
// - Writing zero leaves request bit unchanged.
// - Control bits 31..1 read zero, ignore writes.
// - Config bit 0 stops fast oscillator in sleep.
// - Config bit 1 floats card controls in sleep.
// - Card float covers strobes, enables, width, wait.
// - Socket select, attribute follow address in sleep.
// - Config bit 2 floats static selects, strobes.
// - Config bit 3 treats slow oscillator stable.
// - Config bits 31..4 read zero, ignore writes.
// - Software-caused sleep entry pulses status flag set.
//
// Added by the designer: the register offsets and the APB slave port.
module scc_top
	import scc_pkg::*;
(
	input  wire logic                     pclk,
	input  wire logic                     presetn,
	input  wire logic                     psel,
	input  wire logic                     penable,
	input  wire logic                     pwrite,
	input  wire logic [SCC_ADDR_W-1:0]    paddr,
	input  wire logic [31:0]              pwdata,
	output logic      [31:0]              prdata,
	output logic                          pready,
	output logic                          pslverr,
	output logic                          sleep_request_bit,
	input  wire logic                     sleep_active,
	input  wire logic                     wake_done,
	output logic                          sw_sleep_flag_set,
	output logic                          fast_osc_stop_in_sleep_out,
	input  wire logic                     slow_osc_count_done,
	output logic                          slow_osc_ready,
	input  wire logic [7+SCC_CARD_EN_W-1:0] card_run,
	input  wire logic [2+SCC_CS_W-1:0]    mem_run,
	input  wire logic                     socket_select_run,
	input  wire logic                     card_attr_space_n_run,
	output logic      [7+SCC_CARD_EN_W-1:0] card_out,
	output logic      [7+SCC_CARD_EN_W-1:0] card_oe,
	output logic      [2+SCC_CS_W-1:0]    mem_out,
	output logic      [2+SCC_CS_W-1:0]    mem_oe,
	output logic                          socket_select,
	output logic                          card_attr_space_n
);
	// ****************************************
	// Bus decode
	// ****************************************
	logic                 sleep_req_r;
	logic [SCC_CFG_W-1:0] pwr_cfg_r;
	logic                 wake_d_r;
	logic                 sleep_d_r;
	logic                 map_hit;
	logic                 wr_en;
	logic                 setup;
	logic [31:0]          rd_nxt;

	assign map_hit = (paddr == SCC_OFF_SLEEP_CTRL) || (paddr == SCC_OFF_PWR_CFG)
		|| (paddr == SCC_OFF_STATE);
	assign setup   = psel && !penable;
	assign wr_en   = psel && penable && pwrite && map_hit;
	// Every access completes in its first access cycle.
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !map_hit;

	// ****************************************
	// Sleep request
	// ****************************************
	// A write of one wins over a same-cycle wake-up clear so no request is lost.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sleep_req_r <= SCC_SLEEP_CTRL_RST[SCC_SLEEP_REQ_BIT];
		end else if (wr_en && paddr == SCC_OFF_SLEEP_CTRL && pwdata[SCC_SLEEP_REQ_BIT]) begin
			sleep_req_r <= 1'b1;
		end else if (wake_d_r) begin
			sleep_req_r <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wake_d_r <= 1'b0;
		end else begin
			wake_d_r <= wake_done;
		end
	end

	assign sleep_request_bit = sleep_req_r;

	// ****************************************
	// Sleep entry flag
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sleep_d_r         <= 1'b0;
			sw_sleep_flag_set <= 1'b0;
		end else begin
			sleep_d_r         <= sleep_active;
			sw_sleep_flag_set <= sleep_active && !sleep_d_r && sleep_req_r;
		end
	end

	// ****************************************
	// Configuration
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pwr_cfg_r <= SCC_PWR_CFG_RST;
		end else if (wr_en && paddr == SCC_OFF_PWR_CFG) begin
			pwr_cfg_r <= pwdata[SCC_CFG_W-1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fast_osc_stop_in_sleep_out <= 1'b0;
			slow_osc_ready             <= 1'b0;
		end else begin
			fast_osc_stop_in_sleep_out <= sleep_active && pwr_cfg_r[SCC_FAST_OSC_BIT];
			// Forcing this early on an unsettled oscillator gives unpredictable clocks.
			slow_osc_ready <= slow_osc_count_done || pwr_cfg_r[SCC_SLOW_OK_BIT];
		end
	end

	// ****************************************
	// Read data
	// ****************************************
	always_comb begin
		rd_nxt = 32'h00000000;
		case (paddr)
			SCC_OFF_SLEEP_CTRL: rd_nxt[SCC_SLEEP_REQ_BIT] = sleep_req_r;
			SCC_OFF_PWR_CFG:    rd_nxt[SCC_CFG_W-1:0] = pwr_cfg_r;
			SCC_OFF_STATE: begin
				rd_nxt[SCC_ST_SLEEP_BIT]   = sleep_active;
				rd_nxt[SCC_ST_SLOW_BIT]    = slow_osc_ready;
				rd_nxt[SCC_ST_FASTOFF_BIT] = fast_osc_stop_in_sleep_out;
			end
			default:            rd_nxt = 32'h00000000;
		endcase
	end

	// Read data is captured in the setup cycle so it stands through the access cycle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (setup) begin
			prdata <= rd_nxt;
		end
	end

	// ****************************************
	// Pin control
	// ****************************************
	scc_cfg_if cfg_bus ();
	assign cfg_bus.in_sleep   = sleep_active;
	assign cfg_bus.float_card = pwr_cfg_r[SCC_FLOAT_CARD_BIT];
	assign cfg_bus.float_mem  = pwr_cfg_r[SCC_FLOAT_MEM_BIT];

	scc_pin_ctl u_pins (
		.pclk                  (pclk),
		.presetn               (presetn),
		.cfg                   (cfg_bus.pins),
		.card_run              (card_run),
		.mem_run               (mem_run),
		.socket_select_run     (socket_select_run),
		.card_attr_space_n_run (card_attr_space_n_run),
		.card_out              (card_out),
		.card_oe               (card_oe),
		.mem_out               (mem_out),
		.mem_oe                (mem_oe),
		.socket_select         (socket_select),
		.card_attr_space_n     (card_attr_space_n)
	);
endmodule // scc_top

// file: scc_top_asserts.sv
// Concurrent checks on the ports of the sleep control register block.
// ****************************************
// Port checker
// ****************************************
module scc_chk
	import scc_pkg::*;
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        sleep_request_bit,
	input wire logic        sleep_active,
	input wire logic        wake_done,
	input wire logic        sw_sleep_flag_set,
	input wire logic        fast_osc_stop_in_sleep_out,
	input wire logic        slow_osc_count_done,
	input wire logic        slow_osc_ready,
	input wire logic [8:0]  card_oe,
	input wire logic [5:0]  mem_oe,
	input wire logic        socket_select,
	input wire logic        socket_select_run
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire acc = psel && penable;
	wire set_w = acc && pwrite && paddr == SCC_OFF_SLEEP_CTRL && pwdata[0];
	wire rd_c = acc && !pwrite && paddr == SCC_OFF_SLEEP_CTRL;
	wire rd_g = acc && !pwrite && paddr == SCC_OFF_PWR_CFG;
	sleep_set_a: assert property (set_w |=> sleep_request_bit)
		else $error("request not set");
	wake_clear_a: assert property (wake_done ##1 !set_w |=> !sleep_request_bit)
		else $error("request not cleared");
	req_hold_a: assert property (!set_w && !$past(wake_done) |=> $stable(sleep_request_bit))
		else $error("request moved");
	ctrl_resv_a: assert property (rd_c |-> prdata[31:1] == 31'h0)
		else $error("control reserved bits set");
	cfg_resv_a: assert property (rd_g |-> prdata[31:4] == 28'h0)
		else $error("config reserved bits set");
	osc_stop_a: assert property (fast_osc_stop_in_sleep_out |-> $past(sleep_active))
		else $error("oscillator stopped awake");
	slow_ready_a: assert property (slow_osc_count_done |=> slow_osc_ready)
		else $error("slow oscillator not ready");
	run_drive_a: assert property (!$past(sleep_active) |-> &card_oe && &mem_oe)
		else $error("pins floated awake");
	sock_follow_a: assert property (socket_select == $past(socket_select_run))
		else $error("socket select stale");
	sw_flag_a: assert property ($rose(sleep_active) && sleep_request_bit |=>
		sw_sleep_flag_set ##1 !sw_sleep_flag_set) else $error("flag pulse wrong");
	cover property (set_w ##1 sleep_request_bit);
	cover property ($rose(sleep_active) && sleep_request_bit);
	cover property (wake_done ##2 !sleep_request_bit);
endmodule // scc_chk

bind scc_top scc_chk chk_u (.*);

// file: scc_top_bench.sv
// Self-checking bench for the sleep control and power configuration registers.
// ****************************************
// Bench
// ****************************************
module scc_top_bench
	import scc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, er, sleep_request_bit, sleep_active = 0, wake_done = 0;
	logic sw_sleep_flag_set, fast_osc_stop_in_sleep_out, slow_osc_count_done = 0, slow_osc_ready;
	logic [8:0] card_run = 9'h0A5, card_out, card_oe;
	logic [5:0] mem_run = 6'h2A, mem_out, mem_oe;
	logic socket_select_run = 0, card_attr_space_n_run = 1, socket_select, card_attr_space_n;
	int miscompares = 0, num_checks = 0;
	typedef struct {logic [11:0] a; logic [31:0] d; logic [31:0] e; logic x;} scc_row_s;
	scc_row_s rows [5] = '{'{12'h004, 32'hFFFFFFF7, 32'h00000007, 1'b0},
		'{12'h004, 32'h00000005, 32'h00000005, 1'b0},
		'{12'h000, 32'hFFFFFFFE, 32'h00000000, 1'b0},
		'{12'h000, 32'h00000000, 32'h00000000, 1'b0},
		'{12'h010, 32'hFFFFFFFF, 32'h00000000, 1'b1}};
	scc_top dut_u (.*);
	initial begin
		forever #2 pclk = ~pclk;
	end
	task tick(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		{psel, penable} <= 2'b00;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			miscompares++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task wrap_up;
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		#20000;
		miscompares++;
		wrap_up;
	end
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, SCC_OFF_SLEEP_CTRL, 32'h0);
		chk(rd, SCC_SLEEP_CTRL_RST);
		apb(0, SCC_OFF_PWR_CFG, 32'h0);
		chk(rd, 32'h0);
		$display("test reset done");
		foreach (rows[i]) begin
			apb(1, rows[i].a, rows[i].d);
			chk(er, rows[i].x);
			apb(0, rows[i].a, 32'h0);
			chk(er, rows[i].x);
			chk(rd, rows[i].e);
		end
		$display("test registers done");
		@(posedge pclk) {socket_select_run, card_attr_space_n_run} <= 2'b10;
		tick(2);
		chk({card_oe, card_out, socket_select}, {9'h1FF, card_run, 1'b1});
		chk({mem_oe, mem_out, card_attr_space_n}, {6'h3F, mem_run, 1'b0});
		apb(1, SCC_OFF_PWR_CFG, 32'h7);
		apb(1, SCC_OFF_SLEEP_CTRL, 32'h1);
		tick(0);
		chk(sleep_request_bit, 1'b1);
		apb(1, SCC_OFF_SLEEP_CTRL, 32'h0);
		tick(0);
		chk(sleep_request_bit, 1'b1);
		@(posedge pclk) {sleep_active, socket_select_run, card_attr_space_n_run} <= 3'b101;
		tick(1);
		chk({sw_sleep_flag_set, fast_osc_stop_in_sleep_out}, 2'b11);
		tick(1);
		chk({sw_sleep_flag_set, card_oe, mem_oe, card_out, mem_out}, 31'h7FFF);
		chk({socket_select, card_attr_space_n}, 2'b01);
		apb(0, SCC_OFF_STATE, 32'h0);
		chk(rd, 32'h5);
		apb(1, SCC_OFF_PWR_CFG, 32'h0);
		tick(2);
		chk({fast_osc_stop_in_sleep_out, card_oe, mem_oe, card_out, mem_out}, 31'h3FFFFFFF);
		@(posedge pclk) {sleep_active, wake_done} <= 2'b01;
		@(posedge pclk) wake_done <= 1'b0;
		tick(1);
		chk(sleep_request_bit, 1'b0);
		@(posedge pclk) sleep_active <= 1'b1;
		tick(1);
		chk(sw_sleep_flag_set, 1'b0);
		@(posedge pclk) sleep_active <= 1'b0;
		$display("test sleep done");
		apb(1, SCC_OFF_PWR_CFG, 32'h7);
		apb(1, SCC_OFF_SLEEP_CTRL, 32'h1);
		@(posedge pclk) presetn <= 1'b0;
		tick(1);
		chk({sleep_request_bit, card_oe, mem_oe}, 16'h7FFF);
		@(posedge pclk) presetn <= 1'b1;
		apb(0, SCC_OFF_PWR_CFG, 32'h0);
		chk(rd, {28'h0, SCC_PWR_CFG_RST});
		$display("test warm reset done");
		apb(1, SCC_OFF_PWR_CFG, 32'h8);
		apb(0, SCC_OFF_PWR_CFG, 32'h0);
		chk(rd, 32'h8);
		tick(2);
		chk(slow_osc_ready, 1'b1);
		apb(1, SCC_OFF_PWR_CFG, 32'h0);
		tick(2);
		chk(slow_osc_ready, 1'b0);
		@(posedge pclk) slow_osc_count_done <= 1'b1;
		tick(2);
		chk(slow_osc_ready, 1'b1);
		$display("test slow oscillator done");
		wrap_up;
	end
endmodule // scc_top_bench
